// [rtl/bchrr_top.sv]
// Host register port with the swap-pointer read collision behaviour
//
// Overview of operation
// - Enhanced controller mode via config 7 bit 15
// - Fast host access at config 7 bit 14
// - Hazard only in buffered interface configuration
// - Swap pointer write ends the message sequence
// - Window is four cycles before that write
// - Corrupted read is register ORed with pointer
// - Writes and memory accesses stay unaffected
// - No corruption outside enhanced controller mode
// - Stored values unaltered; later reads correct
// - Auto-clear still clears interrupt status
`timescale 1ns/1ns
`default_nettype none
`include "bchrr_regs.svh"
module bchrr_top #(
    parameter logic IS_PCI = 1'b0           // PCI variant reset default
) (
    input  wire logic                mclk_i,      // System clock
    input  wire logic                rst_i,       // Sync reset, high
    input  wire bchrr_pkg::bchrr_hreq_t hreq_i,   // Host request
    input  wire logic                buffered_i,  // Buffered interface
    input  wire bchrr_pkg::bchrr_mode_t mode_i,   // Terminal mode
    input  wire logic                swap_flip_i, // Swap instruction flips
    input  wire logic                upd_soon_i,  // Pointer write due
    input  wire logic [15:0]         new_ptr_i,   // Updated block pointer
    input  wire logic                irq_set_i,   // Interrupt event
    output logic [15:0]              rdata_o,     // Host read data
    output logic                     rvalid_o,    // Read data valid
    output logic [15:0]              cfg7_o,      // Config register 7
    output logic [15:0]              cfg2_o,      // Config register 2
    output logic [15:0]              ptr_o,       // Parameter field
    output logic                     ptr_wr_o,    // Parameter write pulse
    output logic                     corrupt_o    // Last read corrupted
);
    import bchrr_pkg::*;

    localparam logic [3:0] A_CFG2 = `BCHRR_ADDR_CFG2;
    localparam logic [3:0] A_CFG7 = `BCHRR_ADDR_CFG7;
    localparam logic [3:0] A_ISR  = `BCHRR_ADDR_ISR;

    typedef struct packed {
        logic [15:0] cfg7;
        logic [15:0] cfg2;
        logic [15:0] isr;
        logic [15:0] ptr;
        logic [15:0] rdata;
        logic        rvalid;
        logic        ptr_wr;
        logic        corrupt;
    } bchrr_st_t;

    bchrr_st_t s, next_s;
    logic in_win;
    logic upd;
    logic hazard;
    logic [15:0] reg_val;

    bchrr_win u_win (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .upd_soon_i (upd_soon_i & swap_flip_i),
        .in_win_o   (in_win),
        .upd_o      (upd)
    );

    always_comb begin
        hazard = s.cfg7[`BCHRR_CFG7_ENH_BC_BIT]
               & s.cfg7[`BCHRR_CFG7_FAST_BIT]
               & buffered_i & ~IS_PCI
               & (mode_i == BCHRR_MODE_BC)
               & swap_flip_i & in_win;
        case (hreq_i.addr)
            A_CFG2:  reg_val = s.cfg2;
            A_CFG7:  reg_val = s.cfg7;
            A_ISR:   reg_val = s.isr;
            default: reg_val = 16'h0000;
        endcase
    end

    always_comb begin
        next_s         = s;
        next_s.rvalid  = 1'b0;
        next_s.ptr_wr  = 1'b0;
        if (upd) begin
            next_s.ptr    = new_ptr_i;
            next_s.ptr_wr = 1'b1;
        end
        if (hreq_i.wr & hreq_i.reg_sel) begin
            case (hreq_i.addr)
                A_CFG2:  next_s.cfg2 = hreq_i.wdata;
                A_CFG7:  next_s.cfg7 = hreq_i.wdata;
                default: next_s.cfg2 = next_s.cfg2;
            endcase
        end
        if (hreq_i.rd) begin
            next_s.rvalid = 1'b1;
            if (hreq_i.reg_sel) begin
                next_s.corrupt = hazard;
                next_s.rdata   = hazard ? (reg_val | new_ptr_i)
                                        : reg_val;
                if ((hreq_i.addr == A_ISR) &
                    s.cfg2[`BCHRR_CFG2_AUTOCLR_BIT]) begin
                    next_s.isr = 16'h0000;
                end
            end else begin
                next_s.corrupt = 1'b0;
                next_s.rdata   = 16'h0000;
            end
        end
        if (irq_set_i) begin
            next_s.isr = s.isr | 16'h0001;               // Set wins
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s <= '0;
            s.cfg7 <= IS_PCI ? `BCHRR_CFG7_RST_PCI : `BCHRR_CFG7_RST_NONPCI;
        end else begin
            s <= next_s;
        end
    end

    assign rdata_o   = s.rdata;
    assign rvalid_o  = s.rvalid;
    assign cfg7_o    = s.cfg7;
    assign cfg2_o    = s.cfg2;
    assign ptr_o     = s.ptr;
    assign ptr_wr_o  = s.ptr_wr;
    assign corrupt_o = s.corrupt;

    property p_no_hazard_outside;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & ~in_win) |=> ~corrupt_o;
    endproperty
    a_no_hazard_outside: assert property (p_no_hazard_outside)
        else $error("corruption outside window");
    property p_mode;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & ~cfg7_o[`BCHRR_CFG7_ENH_BC_BIT]) |=> ~corrupt_o;
    endproperty
    a_mode: assert property (p_mode)
        else $error("corruption without enhanced mode");
    property p_fast;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & ~cfg7_o[`BCHRR_CFG7_FAST_BIT]) |=> ~corrupt_o;
    endproperty
    a_fast: assert property (p_fast)
        else $error("corruption without fast access");
    property p_buf;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & ~buffered_i) |=> ~corrupt_o;
    endproperty
    a_buf: assert property (p_buf)
        else $error("corruption in transparent mode");
    property p_or;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & hreq_i.reg_sel & hazard) |=>
            (rdata_o == ($past(reg_val) | $past(new_ptr_i)));
    endproperty
    a_or: assert property (p_or)
        else $error("corrupt value not OR");
    property p_upd;
        @(posedge mclk_i) disable iff (rst_i)
        (upd_soon_i & swap_flip_i & ~in_win & ~upd) |=> ##5 ptr_wr_o;
    endproperty
    a_upd: assert property (p_upd)
        else $error("pointer write not after window");
    property p_rtmode;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & (mode_i != BCHRR_MODE_BC)) |=> ~corrupt_o;
    endproperty
    a_rtmode: assert property (p_rtmode)
        else $error("corruption in non controller mode");
    property p_mem;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & ~hreq_i.reg_sel) |=> ~corrupt_o;
    endproperty
    a_mem: assert property (p_mem)
        else $error("memory read corrupted");
    property p_keep;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & hazard & ~hreq_i.wr & ~irq_set_i) |=>
            (cfg7_o == $past(cfg7_o));
    endproperty
    a_keep: assert property (p_keep)
        else $error("stored value changed by read");
    property p_clr;
        @(posedge mclk_i) disable iff (rst_i)
        (hreq_i.rd & hreq_i.reg_sel & (hreq_i.addr == A_ISR) &
         cfg2_o[`BCHRR_CFG2_AUTOCLR_BIT] & ~irq_set_i) |=> (s.isr == 16'h0000);
    endproperty
    a_clr: assert property (p_clr)
        else $error("auto-clear missed");
    c_corrupt: cover property (@(posedge mclk_i) corrupt_o);
    c_upd: cover property (@(posedge mclk_i) ptr_wr_o);
    c_clean: cover property (@(posedge mclk_i) rvalid_o & ~corrupt_o);
endmodule : bchrr_top
`default_nettype wire

// [rtl/bchrr_win.sv]
// Tracks the four-cycle window before the swap-pointer update write
`timescale 1ns/1ns
`default_nettype none
`include "bchrr_regs.svh"
module bchrr_win (
    input  wire logic mclk_i,       // System clock
    input  wire logic rst_i,        // Sync reset, high
    input  wire logic upd_soon_i,   // Pointer write due in four cycles
    output logic      in_win_o,     // Inside the vulnerable window
    output logic      upd_o         // Pointer update write cycle
);
    import bchrr_pkg::*;
    typedef struct packed {
        bchrr_state_t st;
        logic [2:0]   cnt;
    } bchrr_wst_t;
    bchrr_wst_t s, next_s;

    always_comb begin
        next_s = s;
        case (s.st)
            BCHRR_IDLE: begin
                if (upd_soon_i) begin
                    next_s.st  = BCHRR_WIN;
                    next_s.cnt = `BCHRR_WIN_CYCLES - 3'h1;
                end
            end
            BCHRR_WIN: begin
                if (s.cnt == 3'h0) begin
                    next_s.st = BCHRR_UPD;
                end else begin
                    next_s.cnt = s.cnt - 3'h1;
                end
            end
            BCHRR_UPD: begin
                next_s.st = BCHRR_IDLE;
            end
            default: begin
                next_s.st = BCHRR_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s <= '{st: BCHRR_IDLE, cnt: 3'h0};
        end else begin
            s <= next_s;
        end
    end

    assign in_win_o = (s.st == BCHRR_WIN);
    assign upd_o    = (s.st == BCHRR_UPD);
endmodule : bchrr_win
`default_nettype wire

// [shared/bchrr_pkg.sv]
// Types of the host register-read hazard block
`default_nettype none
package bchrr_pkg;
    typedef enum logic [1:0] {
        BCHRR_IDLE = 2'b00,
        BCHRR_WIN  = 2'b01,
        BCHRR_UPD  = 2'b10
    } bchrr_state_t;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        reg_sel;
        logic [3:0]  addr;
        logic [15:0] wdata;
    } bchrr_hreq_t;

    typedef enum logic [1:0] {
        BCHRR_MODE_BC = 2'b00,
        BCHRR_MODE_RT = 2'b01,
        BCHRR_MODE_MT = 2'b10,
        BCHRR_MODE_RTMT = 2'b11
    } bchrr_mode_t;
endpackage : bchrr_pkg
`default_nettype wire

// [shared/bchrr_regs.svh]
// Constants of the host register-read hazard block
`ifndef BCHRR_REGS_SVH
`define BCHRR_REGS_SVH
`define BCHRR_CFG7_ENH_BC_BIT    15
`define BCHRR_CFG7_FAST_BIT      14
`define BCHRR_CFG2_AUTOCLR_BIT   4
`define BCHRR_CFG7_RST_NONPCI    16'h0000
`define BCHRR_CFG7_RST_PCI       16'h4000
`define BCHRR_WIN_CYCLES         3'h4
// Register offsets on the host port (arbitrary choice)
`define BCHRR_ADDR_CFG2          4'h2
`define BCHRR_ADDR_ISR           4'h6
`define BCHRR_ADDR_CFG7          4'h7
`endif

// [verif/bchrr_host.sv]
// Host processor model on the buffered register port
`timescale 1ns/1ns
`default_nettype none
module bchrr_host (
    input  wire logic              mclk_i, // System clock
    output bchrr_pkg::bchrr_hreq_t hreq_o  // Host request
);
    import bchrr_pkg::*;
    initial hreq_o = '0;
    // One access held for one edge; callers choose when to read
    task automatic access(input logic wr, input logic sel,
                          input logic [3:0] a, input logic [15:0] d);
        @(negedge mclk_i);
        hreq_o <= '{rd: ~wr, wr: wr, reg_sel: sel, addr: a, wdata: d};
        @(negedge mclk_i);
        // Released bus drops rd and wr to zero and shows inverted sel, address and data
        hreq_o <= '{rd: 1'b0, wr: 1'b0, reg_sel: ~sel, addr: ~a,
                    wdata: ~d};
    endtask : access
endmodule : bchrr_host
`default_nettype wire

// [verif/bchrr_top_tb_top.sv]
// Self-checking bench of the host register-read collision block
`timescale 1ns/1ns
`default_nettype none
module bchrr_top_tb_top;
    import bchrr_pkg::*;
    logic        mclk_i      = 1'b0;
    logic        rst_i       = 1'b1;
    logic        buffered_i  = 1'b1;
    bchrr_mode_t mode_i      = BCHRR_MODE_BC;
    logic        swap_flip_i = 1'b1;
    logic        upd_soon_i  = 1'b0;
    logic [15:0] new_ptr_i   = 16'h0A50;
    logic        irq_set_i   = 1'b0;
    bchrr_hreq_t hreq_i;
    logic [15:0] rdata_o, cfg7_o, cfg2_o, ptr_o, v, c7;
    logic        rvalid_o, ptr_wr_o, corrupt_o, pw;
    int          num_errors  = 0;
    int          num_checks  = 0;

    initial begin
        forever #10 mclk_i = ~mclk_i;
    end

    bchrr_host i_host (.mclk_i(mclk_i), .hreq_o(hreq_i));
    bchrr_top #(.IS_PCI(1'b0)) i_dut (
        .mclk_i(mclk_i), .rst_i(rst_i), .hreq_i(hreq_i),
        .buffered_i(buffered_i), .mode_i(mode_i),
        .swap_flip_i(swap_flip_i), .upd_soon_i(upd_soon_i),
        .new_ptr_i(new_ptr_i), .irq_set_i(irq_set_i),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cfg7_o(cfg7_o),
        .cfg2_o(cfg2_o), .ptr_o(ptr_o), .ptr_wr_o(ptr_wr_o),
        .corrupt_o(corrupt_o));

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict;
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic rd(input logic sel, input logic [3:0] a,
                      output logic [15:0] d);
        i_host.access(1'b0, sel, a, 16'h0000);
        chk({15'h0000, rvalid_o}, 16'h0001);
        @(negedge mclk_i);
        d = rdata_o;
    endtask : rd

    // Read taken two edges after the early warning, inside the window
    task automatic hz(input logic sel, input logic [3:0] a,
                      output logic [15:0] d, output logic p);
        @(negedge mclk_i);
        upd_soon_i = 1'b1;
        @(negedge mclk_i);
        upd_soon_i = 1'b0;
        rd(sel, a, d);
        repeat (2) @(negedge mclk_i);
        p = ptr_wr_o;
    endtask : hz

    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end

    initial begin
        repeat (5) @(negedge mclk_i);
        rst_i = 1'b0;
        chk(cfg7_o, 16'h0000);
        // Case 0 meets every condition; each other case drops one
        for (int i = 0; i < 8; i++) begin
            c7 = (i == 2) ? 16'h8000 : (i == 3) ? 16'h4000 : 16'hC000;
            buffered_i = (i != 1);
            swap_flip_i = (i != 7);
            mode_i = (i > 3 && i < 7) ? bchrr_mode_t'(2'(i - 3))
                                      : BCHRR_MODE_BC;
            i_host.access(1'b1, 1'b1, 4'h7, c7);
            chk(cfg7_o, c7);
            hz(1'b1, 4'h7, v, pw);
            chk(v, i == 0 ? c7 | new_ptr_i : c7);
            chk({15'h0000, corrupt_o}, {15'h0000, i == 0});
            chk({15'h0000, pw}, {15'h0000, i != 7});
            if (i == 0) begin
                chk(ptr_o, new_ptr_i);
            end
            rd(1'b1, 4'h7, v);
            chk(v, c7);
        end
        swap_flip_i = 1'b1;
        hz(1'b0, 4'h3, v, pw);
        chk(v, 16'h0000);
        chk({15'h0000, corrupt_o}, 16'h0000);
        i_host.access(1'b1, 1'b1, 4'h2, 16'h0010);
        chk(cfg2_o, 16'h0010);
        irq_set_i = 1'b1;
        @(negedge mclk_i);
        irq_set_i = 1'b0;
        hz(1'b1, 4'h6, v, pw);
        chk(v, 16'h0A51);
        chk({15'h0000, corrupt_o}, 16'h0001);
        rd(1'b1, 4'h6, v);
        chk(v, 16'h0000);
        // Mid-run reset brings the configuration back to its defaults
        rst_i = 1'b1;
        @(negedge mclk_i);
        rst_i = 1'b0;
        chk(cfg7_o, 16'h0000);
        chk(cfg2_o, 16'h0000);
        print_verdict();
    end
endmodule : bchrr_top_tb_top
`default_nettype wire
